// ==== hw/clock_gate_map.svh ====
`ifndef CLOCK_GATE_MAP_SVH
`define CLOCK_GATE_MAP_SVH
// Notes on behaviour
// - set bit clocks unit, clear bit disables it
// - access to unclocked unit raises bus fault
// - deep-sleep gate register resets to zero
// - run, sleep or deep-sleep register selects gating
// - sleep registers apply only with auto-gating set
// - bits 16..19 gate timers a..d
// - bits 12, 14 gate two-wire ports a, b
// - bits 4, 5 gate sync serial a, b
// - bits 0, 1 gate async serial a, b
// - reserved bits read zero, software preserves them

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RUN_CLOCK_CONFIG_OFS      12'h060
`define RUN_CLOCK_GATE_1_OFS      12'h104
`define SLEEP_CLOCK_GATE_1_OFS    12'h114
`define DEEP_SLEEP_CLOCK_GATE_1_OFS 12'h124

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define AUTO_CLOCK_GATING_SEL_BIT 27
`define GATE_WRITE_MASK           32'h030F5033
`define GATE_RESET_VALUE          32'h00000000
`define CONFIG_RESET_VALUE        32'h00000000
`define ASYNC_SERIAL_A_BIT        0
`define SYNC_SERIAL_A_BIT         4
`define TWOWIRE_PORT_A_BIT        12
`define TWOWIRE_PORT_B_BIT        14
`define GP_TIMER_A_BIT            16
`define COMPARATOR_A_BIT          24
`define AXI_RESP_OKAY             2'h0
`define AXI_RESP_SLVERR           2'h2
`endif

// ==== hw/clock_gate_pkg.sv ====
package clock_gate_pkg;
	// operating state reported by the power controller
	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_SLEEP,
		MODE_DEEP
	} power_mode_t;

	// the three parallel gating registers
	typedef struct packed {
		logic [31:0] run;
		logic [31:0] sleep;
		logic [31:0] deep;
	} gate_set_t;
endpackage : clock_gate_pkg

// ==== hw/deep_sleep_clock_gate_reg.sv ====
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "clock_gate_map.svh"
module deep_sleep_clock_gate_reg #(
	parameter int ADDR_W = 12
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [ADDR_W-1:0]         awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [ADDR_W-1:0]         araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	input  wire clock_gate_pkg::power_mode_t power_mode,
	input  wire logic [31:0]               unit_access,
	output logic [31:0]                    unit_clk_en,
	output logic                           bus_fault
);
	import clock_gate_pkg::*;

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	// decode reads address bits 11:0, so fewer than twelve cannot serve
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie between 12 and 32");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	gate_set_t         gates_q;      // run, sleep and deep gating words
	logic              acg_q;        // auto_clock_gating_sel
	logic [ADDR_W-1:0] waddr_q;      // latched write address
	logic [31:0]       wdata_q;      // latched write data
	logic [3:0]        wstrb_q;      // latched byte enables
	logic              aw_full_q;    // address held
	logic              w_full_q;     // data held
	logic              do_wr;        // both halves present, answer free
	logic [31:0]       wr_mask;      // byte lanes to bit mask
	logic              wr_hit;       // write address is mapped
	logic [31:0]       rd_word;      // read mux
	logic              rd_hit;       // read address is mapped
	logic [31:0]       eff_gate;     // gating word now in force

	assign do_wr = aw_full_q && w_full_q && !bvalid;

	// byte lanes expand to a bit mask, one per lane
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign wr_mask[8*i +: 8] = {8{wstrb_q[i]}};
	end

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	// address and data are taken in either order, one write in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			aw_full_q <= 1'b0;
			waddr_q   <= '0;
		end else if (awvalid && awready) begin
			awready   <= 1'b0;
			aw_full_q <= 1'b1;
			waddr_q   <= awaddr;
		end else if (bvalid && bready) begin
			// reopen only once the answer has gone
			awready   <= 1'b1;
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready   <= 1'b1;
			w_full_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (wvalid && wready) begin
			wready   <= 1'b0;
			w_full_q <= 1'b1;
			wdata_q  <= wdata;
			wstrb_q  <= wstrb;
		end else if (bvalid && bready) begin
			wready   <= 1'b1;
			w_full_q <= 1'b0;
		end
	end

	// address decode for writes
	always_comb begin
		case (waddr_q[11:0])
			`RUN_CLOCK_CONFIG_OFS,
			`RUN_CLOCK_GATE_1_OFS,
			`SLEEP_CLOCK_GATE_1_OFS,
			`DEEP_SLEEP_CLOCK_GATE_1_OFS: wr_hit = (waddr_q[ADDR_W-1:0] >> 12) == '0;
			default:                     wr_hit = 1'b0;
		endcase
	end

	// write response; unmapped addresses answer slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `AXI_RESP_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// gating registers
	// ----------------------------------------------------------------
	// only the writable positions store; reserved ones stay zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gates_q <= {3{`GATE_RESET_VALUE}};
		end else if (do_wr && wr_hit) begin
			case (waddr_q[11:0])
				`RUN_CLOCK_GATE_1_OFS:
					gates_q.run <= ((gates_q.run & ~wr_mask) | (wdata_q & wr_mask))
						& `GATE_WRITE_MASK;
				`SLEEP_CLOCK_GATE_1_OFS:
					gates_q.sleep <= ((gates_q.sleep & ~wr_mask) | (wdata_q & wr_mask))
						& `GATE_WRITE_MASK;
				`DEEP_SLEEP_CLOCK_GATE_1_OFS:
					gates_q.deep <= ((gates_q.deep & ~wr_mask) | (wdata_q & wr_mask))
						& `GATE_WRITE_MASK;
				default: gates_q <= gates_q;
			endcase
		end
	end

	// auto-gating select lives in its own configuration word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acg_q <= `CONFIG_RESET_VALUE == 0 ? 1'b0 : 1'b1;
		end else if (do_wr && wr_hit && waddr_q[11:0] == `RUN_CLOCK_CONFIG_OFS
				&& wstrb_q[`AUTO_CLOCK_GATING_SEL_BIT / 8]) begin
			acg_q <= wdata_q[`AUTO_CLOCK_GATING_SEL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		rd_hit  = (araddr >> 12) == '0;
		case (araddr[11:0])
			`RUN_CLOCK_CONFIG_OFS:        rd_word[`AUTO_CLOCK_GATING_SEL_BIT] = acg_q;
			`RUN_CLOCK_GATE_1_OFS:        rd_word = gates_q.run;
			`SLEEP_CLOCK_GATE_1_OFS:      rd_word = gates_q.sleep;
			`DEEP_SLEEP_CLOCK_GATE_1_OFS: rd_word = gates_q.deep;
			default:                      rd_hit  = 1'b0;
		endcase
	end

	// one read at a time; the answer comes one edge after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= `AXI_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// gate selection and fault
	// ----------------------------------------------------------------
	// sleep words only count when auto-gating is selected
	always_comb begin
		eff_gate = gates_q.run;
		if (acg_q && power_mode == MODE_DEEP) begin
			eff_gate = gates_q.deep;
		end else if (acg_q && power_mode == MODE_SLEEP) begin
			eff_gate = gates_q.sleep;
		end
	end

	// registered enables, so a unit sees a glitch-free level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unit_clk_en <= `GATE_RESET_VALUE;
		end else begin
			unit_clk_en <= eff_gate;
		end
	end

	// an access to an unclocked unit faults one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_fault <= 1'b0;
		end else begin
			bus_fault <= |(unit_access & ~unit_clk_en);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_deep_write;
		do_wr && wr_hit && waddr_q[11:0] == `DEEP_SLEEP_CLOCK_GATE_1_OFS && wstrb_q == 4'hF;
	endsequence

	AST_RESET_ZERO: assert property (@(posedge aclk)
		!aresetn |=> gates_q.deep == `GATE_RESET_VALUE && unit_clk_en == '0)
		else $error("deep gate not zero after reset");
	AST_RSVD_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
		(gates_q.deep & ~`GATE_WRITE_MASK) == '0)
		else $error("reserved gate bit set");
	AST_DEEP_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		s_deep_write |=> gates_q.deep == ($past(wdata_q) & `GATE_WRITE_MASK))
		else $error("deep gate write lost");
	AST_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
		|(unit_access & ~unit_clk_en) |=> bus_fault)
		else $error("gated access did not fault");
	AST_NO_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
		(unit_access & ~unit_clk_en) == '0 |=> !bus_fault)
		else $error("fault without gated access");
	AST_DEEP_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
		acg_q && power_mode == MODE_DEEP |=> unit_clk_en == $past(gates_q.deep))
		else $error("deep gating not applied");
	AST_NO_ACG: assert property (@(posedge aclk) disable iff (!aresetn)
		!acg_q |=> unit_clk_en == $past(gates_q.run))
		else $error("sleep gating applied without auto-gating");
	AST_SLEEP_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
		acg_q && power_mode == MODE_SLEEP |=> unit_clk_en == $past(gates_q.sleep))
		else $error("sleep gating not applied");
	AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");
endmodule : deep_sleep_clock_gate_reg

// ==== tb/tb.sv ====
`timescale 1ns/1ns
`include "clock_gate_map.svh"
module tb;
	import clock_gate_pkg::*;
	// ----------------------------------------------------------------
	// bench signals
	// ----------------------------------------------------------------
	logic        aclk = 1'b0;     // 25 MHz system clock
	logic        aresetn = 1'b0;  // synchronous, active low
	logic [11:0] awaddr = 12'h000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0]  wstrb = 4'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	power_mode_t power_mode = MODE_RUN;
	logic [31:0] unit_access = 32'h00000000;
	logic        awready, wready, bvalid, arready, rvalid, bus_fault;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, unit_clk_en;
	int          num_errors = 0;  // mismatches seen
	int          checked = 0;     // comparisons made
	always #20 aclk = ~aclk;
	deep_sleep_clock_gate_reg #(.ADDR_W(12)) i_deep_sleep_clock_gate_reg (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .power_mode(power_mode),
		.unit_access(unit_access), .unit_clk_en(unit_clk_en), .bus_fault(bus_fault));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// writable gate bits, built bit by bit rather than copied
	function automatic logic [31:0] gate_mask();
		logic [31:0] m;
		m = 32'h00000000;
		foreach (m[i]) m[i] = (i < 2) || (i == 4) || (i == 5) || (i == 12) || (i == 14) ||
			(i >= 16 && i <= 19) || (i == 24) || (i == 25);
		return m;
	endfunction : gate_mask
	// word that should be in force for the mode and auto-gating setting
	function automatic logic [31:0] exp_en(input logic auto_clock_gating_sel, input power_mode_t m,
		input logic [31:0] r, input logic [31:0] s, input logic [31:0] d);
		if (auto_clock_gating_sel && m == MODE_DEEP) return d;
		if (auto_clock_gating_sel && m == MODE_SLEEP) return s;
		return r;
	endfunction : exp_en
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	// ----------------------------------------------------------------
	// bus master tasks
	// ----------------------------------------------------------------
	// address and data offered together, each dropped once taken
	// bwait holds bready low for that many edges, so the answer must wait
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp, input int bwait = 0);
		int k;
		k = 0;
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= (bwait == 0);
		// no cycle count assumed: only the watchdog ends a hang
		forever begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bready && bvalid === 1'b1) break;
			k++;
			if (k >= bwait) bready <= 1'b1;
		end
		resp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [11:0] regs [4];
		logic [31:0] d, w [3], en, v;
		logic [1:0]  r;
		regs = '{`RUN_CLOCK_CONFIG_OFS, `RUN_CLOCK_GATE_1_OFS, `SLEEP_CLOCK_GATE_1_OFS,
			`DEEP_SLEEP_CLOCK_GATE_1_OFS};
		void'($urandom(77));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		// every register and the enables start cleared
		check(unit_clk_en, 32'h00000000, "enables after reset");
		foreach (regs[i]) begin
			rd(regs[i], d, r);
			check(d, 32'h00000000, "reset value");
			check({30'h0, r}, {30'h0, `AXI_RESP_OKAY}, "reset read resp");
		end
		$display("test reset done");
		// random words, all-ones corner first: only gate bits stick
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 32'hFFFFFFFF : $urandom;
			wr(`DEEP_SLEEP_CLOCK_GATE_1_OFS, d, 4'hF, r);
			check({30'h0, r}, {30'h0, `AXI_RESP_OKAY}, "write resp");
			rd(`DEEP_SLEEP_CLOCK_GATE_1_OFS, v, r);
			check(v, d & gate_mask(), "deep readback");
		end
		// lane 0 only: upper lanes keep their ones
		wr(`DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'hFFFFFFFF, 4'hF, r);
		wr(`DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h00000000, 4'h1, r);
		rd(`DEEP_SLEEP_CLOCK_GATE_1_OFS, v, r);
		check(v, gate_mask() & 32'hFFFFFF00, "strobe lanes");
		// late bready: the answer has to stand until it is taken
		wr(`DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'h00000033, 4'hF, r, 3);
		check({30'h0, r}, {30'h0, `AXI_RESP_OKAY}, "late bready resp");
		rd(`DEEP_SLEEP_CLOCK_GATE_1_OFS, v, r);
		check(v, 32'h00000033 & gate_mask(), "late bready readback");
		$display("test readback done");
		// distinct words in the three parallel registers
		for (int i = 0; i < 3; i++) begin
			w[i] = $urandom & gate_mask();
			wr(regs[i + 1], w[i], 4'hF, r);
		end
		for (int auto_clock_gating_sel = 0; auto_clock_gating_sel < 2; auto_clock_gating_sel++) begin
			wr(`RUN_CLOCK_CONFIG_OFS, (auto_clock_gating_sel == 1) ? 32'hFFFFFFFF : 32'h00000000, 4'hF, r);
			rd(`RUN_CLOCK_CONFIG_OFS, v, r);
			check(v, (auto_clock_gating_sel == 1) ? 32'h08000000 : 32'h00000000, "config readback");
			for (int m = 0; m < 3; m++) begin
				@(posedge aclk);
				power_mode <= power_mode_t'(m);
				@(posedge aclk);
				#1;
				en = exp_en(auto_clock_gating_sel[0], power_mode_t'(m), w[0], w[1], w[2]);
				check(unit_clk_en, en, "enable selection");
			end
		end
		$display("test selection done");
		// deep word in force: access to a cleared unit faults next cycle
		for (int i = 0; i < 8; i++) begin
			v = (i == 0) ? en : (i == 1) ? (gate_mask() & ~en) : ($urandom & gate_mask());
			@(posedge aclk);
			unit_access <= v;
			@(posedge aclk);
			#1;
			check({31'h0, bus_fault}, {31'h0, |(v & ~en)}, "fault pulse");
		end
		@(posedge aclk);
		unit_access <= 32'h00000000;
		$display("test fault done");
		// unmapped place: error response, nothing stored
		wr(12'h200, 32'hFFFFFFFF, 4'hF, r);
		check({30'h0, r}, {30'h0, `AXI_RESP_SLVERR}, "unmapped write");
		rd(12'h200, v, r);
		check({30'h0, r}, {30'h0, `AXI_RESP_SLVERR}, "unmapped read");
		check(v, 32'h00000000, "unmapped data");
		$display("test unmapped done");
		// reset in mid-run with deep word and auto-gating in force
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		check(unit_clk_en, 32'h00000000, "enables after mid-run reset");
		rd(`DEEP_SLEEP_CLOCK_GATE_1_OFS, v, r);
		check(v, 32'h00000000, "deep word after mid-run reset");
		rd(`RUN_CLOCK_CONFIG_OFS, v, r);
		check(v, 32'h00000000, "config after mid-run reset");
		$display("test mid-run reset done");
		final_report();
	end
	// hang guard, far beyond the 160-odd cycles the tests take
	initial begin
		#(40 * 20000);
		num_errors++;
		final_report();
	end
endmodule : tb
